// ==== hdl/ccrc_params.svh ====
// Register map, field positions, reset values and timing counts
`ifndef CCRC_PARAMS_SVH
`define CCRC_PARAMS_SVH
`define CCRC_OFF_RESET_CAUSE_RECORD 12'h05c
`define CCRC_OFF_RCC 12'h060
`define CCRC_OFF_IST 12'h064
`define CCRC_OFF_IMSK 12'h068
`define CCRC_RCC_ACG 27
`define CCRC_RCC_SDIV_HI 26
`define CCRC_RCC_SDIV_LO 23
`define CCRC_RCC_USESDIV 22
`define CCRC_RCC_USEPDIV 20
`define CCRC_RCC_PDIV_HI 19
`define CCRC_RCC_PDIV_LO 17
`define CCRC_RCC_BYPASS 11
`define CCRC_SDIV_RST 4'hf
`define CCRC_PDIV_RST 3'h7
`define CCRC_PDIV_MAX 3'h5
`define CCRC_MIN_SDIV 4'h3
`define CCRC_SDIV_ZERO 4'h0
`define CCRC_SDIV_ONE 4'h1
`define CCRC_CAUSE_PIN 6'h01
`define CCRC_SETTLE 3'h4
`define CCRC_RESP_OK 2'h0
`define CCRC_RESP_ERR 2'h2
`define CCRC_IST_CAP 0
`define CCRC_IST_CLAMP 1
`define CCRC_SYSCLK_MHZ 25
`endif

// ==== hdl/ccrc_pkg.sv ====
// Shared types of the clock configuration and reset cause block
package ccrc_pkg;
  typedef struct packed {
    logic regulator_fail_cause;
    logic soft_reset_cause;
    logic watchdog_cause;
    logic brownout_cause;
    logic poweron_cause;
    logic pin_reset_cause;
  } ccrc_cause_t;
  typedef enum logic [1:0] {
    CCRC_PM_RUN = 2'b00,
    CCRC_PM_SLEEP = 2'b01,
    CCRC_PM_DEEP = 2'b10
  } ccrc_pmode_t;
  typedef struct packed {
    logic [31:0] run_gating_set;
    logic [31:0] sleep_gating_set;
    logic [31:0] deep_sleep_gating_set;
  } ccrc_gating_t;
  typedef struct packed {
    logic osc_select;
    logic system_divisor_active;
    logic [3:0] system_divisor;
    logic pwm_divided;
    logic [2:0] pwm_divisor;
  } ccrc_clkctl_t;
endpackage

// ==== hdl/ccrc_top.sv ====
// Reset cause record and run-mode clock configuration with AXI4-Lite access
//
// Functional notes
// - A pin reset sets the pin cause flag and clears all others.
// - Any other reset keeps set flags and adds its own flag.
// - Bit 5 records regulator power loss, bit 4 a software reset.
// - Bit 3 records a watchdog reset, bit 2 a brown-out reset.
// - Bit 1 records power-on, bit 0 the reset pin; bits 31:6 reserved.
// - Cause record has no fixed reset value; it follows the causes seen.
// - Auto gating set selects sleep or deep-sleep gating set in those modes.
// - Auto gating clear keeps the run gating set in both sleep modes.
// - Run mode always uses the run gating set.
// - System divisor divides by value plus one; low codes reserved.
// - Divisor below minimum with the PLL is replaced by the minimum.
// - Use-system-divider set routes the system clock through the divider.
// - The divider always applies while the PLL is the source.
// - Use-PWM-divider set clocks PWM from the PWM divider output.
// - Bypass set runs from the oscillator, clear from the divided PLL.
// - PWM divisor divides by 2 to 64; codes 6 and 7 give 64.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ccrc_params.svh"

module ccrc_top
  import ccrc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire ccrc_cause_t cause_in,
  input wire ccrc_pmode_t pmode_in,
  input wire ccrc_gating_t gating_in,
  output logic [31:0] periph_clk_en,
  output ccrc_clkctl_t clkctl,
  output logic sys_tick,
  output logic pwm_tick,
  output logic irq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Helpers
  function automatic logic [3:0] eff_divisor(input logic [3:0] code, input logic bypass);
    logic [3:0] r;
    r = code;
    if (!bypass && code < `CCRC_MIN_SDIV) begin
      r = `CCRC_MIN_SDIV;
    end else if (code == `CCRC_SDIV_ZERO) begin
      r = `CCRC_SDIV_ONE;
    end
    return r;
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [11:0] off);
    return (a[31:12] == 20'h0_0000) && (a[11:2] == off[11:2]);
  endfunction

  // ==========================================================
  // Cause input synchroniser and capture after reset release
  ccrc_cause_t sync1_reg, sync2_reg, sync3_reg, filt_reg;
  logic [2:0] settle_reg;
  logic cap_done_reg;
  logic cap_go;
  logic [5:0] reset_cause_record_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg <= '0;
    end else if (ce) begin
      sync1_reg <= cause_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 6; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          filt_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  assign cap_go = ce && !cap_done_reg && (settle_reg == `CCRC_SETTLE);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      settle_reg <= 3'h0;
      cap_done_reg <= 1'b0;
    end else if (ce && !cap_done_reg) begin
      if (cap_go) begin
        cap_done_reg <= 1'b1;
      end else begin
        settle_reg <= settle_reg + 3'h1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite write side
  logic aw_got_reg, w_got_reg, do_wr, aw_take, w_take;
  logic [31:0] awaddr_reg, wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_full_next, w_full_next;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_wr = ce && aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign aw_full_next = aw_got_reg ? !do_wr : aw_take;
  assign w_full_next = w_got_reg ? !do_wr : w_take;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCRC_RESP_OK;
    end else if (ce) begin
      aw_got_reg <= aw_full_next;
      w_got_reg <= w_full_next;
      s_axi_awready <= !aw_full_next;
      s_axi_wready <= !w_full_next;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (hit(awaddr_reg, `CCRC_OFF_RESET_CAUSE_RECORD) || hit(awaddr_reg, `CCRC_OFF_RCC) ||
                        hit(awaddr_reg, `CCRC_OFF_IST) || hit(awaddr_reg, `CCRC_OFF_IMSK)) ?
                       `CCRC_RESP_OK : `CCRC_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic wr_reset_cause_record, wr_rcc, wr_ist, wr_imsk;
  assign wr_reset_cause_record = do_wr && hit(awaddr_reg, `CCRC_OFF_RESET_CAUSE_RECORD);
  assign wr_rcc = do_wr && hit(awaddr_reg, `CCRC_OFF_RCC);
  assign wr_ist = do_wr && hit(awaddr_reg, `CCRC_OFF_IST);
  assign wr_imsk = do_wr && hit(awaddr_reg, `CCRC_OFF_IMSK);

  // ==========================================================
  // Reset cause record: no reset term, survives nrst
  always_ff @(posedge clk_sys) begin
    if (cap_go) begin
      if (filt_reg.pin_reset_cause) begin
        reset_cause_record_reg <= `CCRC_CAUSE_PIN;
      end else begin
        reset_cause_record_reg <= reset_cause_record_reg | filt_reg;
      end
    end else if (wr_reset_cause_record && wstrb_reg[0]) begin
      reset_cause_record_reg <= wdata_reg[5:0];
    end
  end

  // ==========================================================
  // Run-mode clock configuration
  logic acg_reg, usesdiv_reg, usepdiv_reg, bypass_reg;
  logic [3:0] sdiv_reg;
  logic [2:0] pdiv_reg;
  logic [31:0] rcc_img, rcc_new;
  logic clamp_evt;

  assign rcc_img = {4'h0, acg_reg, sdiv_reg, usesdiv_reg, 1'b0, usepdiv_reg, pdiv_reg,
                    5'h00, bypass_reg, 11'h000};
  assign rcc_new = merge(rcc_img, wdata_reg, wstrb_reg);
  assign clamp_evt = wr_rcc && !rcc_new[`CCRC_RCC_BYPASS] &&
                     (rcc_new[`CCRC_RCC_SDIV_HI:`CCRC_RCC_SDIV_LO] < `CCRC_MIN_SDIV);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acg_reg <= 1'b0;
      sdiv_reg <= `CCRC_SDIV_RST;
      usesdiv_reg <= 1'b0;
      usepdiv_reg <= 1'b0;
      pdiv_reg <= `CCRC_PDIV_RST;
      bypass_reg <= 1'b1;
    end else if (wr_rcc) begin
      acg_reg <= rcc_new[`CCRC_RCC_ACG];
      sdiv_reg <= rcc_new[`CCRC_RCC_SDIV_HI:`CCRC_RCC_SDIV_LO];
      usesdiv_reg <= rcc_new[`CCRC_RCC_USESDIV];
      usepdiv_reg <= rcc_new[`CCRC_RCC_USEPDIV];
      pdiv_reg <= rcc_new[`CCRC_RCC_PDIV_HI:`CCRC_RCC_PDIV_LO];
      bypass_reg <= rcc_new[`CCRC_RCC_BYPASS];
    end
  end

  // ==========================================================
  // Interrupt status (write one to clear, set wins) and mask
  logic [1:0] ist_reg, imsk_reg, ist_next, imsk_next, ist_set;
  assign ist_set = {clamp_evt, cap_go};

  always_comb begin
    ist_next = ist_reg;
    imsk_next = imsk_reg;
    if (wr_ist && wstrb_reg[0]) begin
      ist_next = ist_next & ~wdata_reg[1:0];
    end
    ist_next = ist_next | ist_set;
    if (wr_imsk && wstrb_reg[0]) begin
      imsk_next = wdata_reg[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ist_reg <= 2'h0;
      imsk_reg <= 2'h0;
      irq <= 1'b0;
    end else if (ce) begin
      ist_reg <= ist_next;
      imsk_reg <= imsk_next;
      irq <= |(ist_next & imsk_next);
    end
  end

  // ==========================================================
  // AXI4-Lite read side
  logic ar_take;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CCRC_RESP_OK;
    end else if (ce) begin
      s_axi_arready <= s_axi_rvalid ? s_axi_rready : !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CCRC_RESP_OK;
        if (hit(s_axi_araddr, `CCRC_OFF_RESET_CAUSE_RECORD)) begin
          s_axi_rdata <= {26'h000_0000, reset_cause_record_reg};
        end else if (hit(s_axi_araddr, `CCRC_OFF_RCC)) begin
          s_axi_rdata <= rcc_img;
        end else if (hit(s_axi_araddr, `CCRC_OFF_IST)) begin
          s_axi_rdata <= {30'h0000_0000, ist_reg};
        end else if (hit(s_axi_araddr, `CCRC_OFF_IMSK)) begin
          s_axi_rdata <= {30'h0000_0000, imsk_reg};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `CCRC_RESP_ERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Clock selection, gating and divided tick outputs
  logic [3:0] eff_sdiv;
  logic div_on;
  logic [4:0] sdiv_cnt_reg;
  logic [6:0] pdiv_cnt_reg, pdiv_last;
  logic [2:0] pdiv_sh;

  assign eff_sdiv = eff_divisor(sdiv_reg, bypass_reg);
  assign div_on = usesdiv_reg || !bypass_reg;
  assign pdiv_sh = (pdiv_reg > `CCRC_PDIV_MAX) ? `CCRC_PDIV_MAX : pdiv_reg;
  assign pdiv_last = 7'((7'h02 << pdiv_sh) - 7'h01);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      periph_clk_en <= 32'h0000_0000;
      clkctl <= '0;
    end else if (ce) begin
      unique case (pmode_in)
        CCRC_PM_RUN: periph_clk_en <= gating_in.run_gating_set;
        CCRC_PM_SLEEP: periph_clk_en <= acg_reg ? gating_in.sleep_gating_set : gating_in.run_gating_set;
        CCRC_PM_DEEP: periph_clk_en <= acg_reg ? gating_in.deep_sleep_gating_set : gating_in.run_gating_set;
        default: periph_clk_en <= gating_in.run_gating_set;
      endcase
      clkctl.osc_select <= bypass_reg;
      clkctl.system_divisor_active <= div_on;
      clkctl.system_divisor <= eff_sdiv;
      clkctl.pwm_divided <= usepdiv_reg;
      clkctl.pwm_divisor <= pdiv_sh;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sdiv_cnt_reg <= 5'h00;
      pdiv_cnt_reg <= 7'h00;
      sys_tick <= 1'b0;
      pwm_tick <= 1'b0;
    end else if (ce) begin
      if (!div_on || sdiv_cnt_reg >= {1'b0, eff_sdiv}) begin
        sdiv_cnt_reg <= 5'h00;
        sys_tick <= 1'b1;
      end else begin
        sdiv_cnt_reg <= sdiv_cnt_reg + 5'h01;
        sys_tick <= 1'b0;
      end
      if (!usepdiv_reg || pdiv_cnt_reg >= pdiv_last) begin
        pdiv_cnt_reg <= 7'h00;
        pwm_tick <= 1'b1;
      end else begin
        pdiv_cnt_reg <= pdiv_cnt_reg + 7'h01;
        pwm_tick <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence cap_pin_s;
    cap_go && filt_reg.pin_reset_cause;
  endsequence
  sequence cap_other_s;
    cap_go && !filt_reg.pin_reset_cause;
  endsequence

  pin_clears_a: assert property (cap_pin_s |=> reset_cause_record_reg == `CCRC_CAUSE_PIN)
    else $error("pin reset did not clear other causes");
  causes_accum_a: assert property (cap_other_s |=> reset_cause_record_reg == ($past(reset_cause_record_reg) | $past(filt_reg)))
    else $error("non-pin reset causes did not accumulate");
  hi_cause_bits_a: assert property (cap_other_s and filt_reg[5:4] != 2'h0 |=>
    (reset_cause_record_reg[5:4] & $past(filt_reg[5:4])) == $past(filt_reg[5:4]))
    else $error("regulator or software cause lost");
  mid_cause_bits_a: assert property (cap_other_s and filt_reg[3:2] != 2'h0 |=>
    (reset_cause_record_reg[3:2] & $past(filt_reg[3:2])) == $past(filt_reg[3:2]))
    else $error("watchdog or brown-out cause lost");
  reset_cause_record_read_a: assert property (ar_take && hit(s_axi_araddr, `CCRC_OFF_RESET_CAUSE_RECORD) |=> s_axi_rvalid &&
    s_axi_rdata[31:6] == 26'h000_0000 && s_axi_rdata[5:0] == $past(reset_cause_record_reg))
    else $error("cause record read wrong");
  capture_once_a: assert property (cap_go |=> !cap_go [*8])
    else $error("cause capture repeated");
  gating_sel_a: assert property (ce && pmode_in == CCRC_PM_SLEEP |=> periph_clk_en ==
    ($past(acg_reg) ? $past(gating_in.sleep_gating_set) : $past(gating_in.run_gating_set)))
    else $error("sleep gating set wrong");
  run_gating_a: assert property (ce && pmode_in == CCRC_PM_RUN |=>
    periph_clk_en == $past(gating_in.run_gating_set))
    else $error("run gating set not used");
  min_divisor_a: assert property (ce && !bypass_reg |=>
    clkctl.system_divisor >= `CCRC_MIN_SDIV && clkctl.system_divisor_active)
    else $error("divisor below minimum with PLL");
  divider_use_a: assert property (ce && usesdiv_reg |=> clkctl.system_divisor_active)
    else $error("system divider not applied");
  osc_select_a: assert property (ce |=> clkctl.osc_select == $past(bypass_reg))
    else $error("oscillator select mismatch");
  pwm_undiv_a: assert property (ce && !usepdiv_reg |=> pwm_tick)
    else $error("undivided PWM clock missing");
  pwm_pow2_a: assert property (ce && usepdiv_reg && pdiv_sh == 3'h0 && pdiv_cnt_reg == 7'h00 ##1
    ce && usepdiv_reg && pdiv_sh == 3'h0 |=> pwm_tick)
    else $error("PWM divide by two wrong");
  reset_cause_record_write_a: assert property (wr_reset_cause_record && wstrb_reg[0] && !cap_go |=> reset_cause_record_reg == $past(wdata_reg[5:0]))
    else $error("cause record write not stored");
  sys_div_a: assert property (ce && bypass_reg && !usesdiv_reg |=> sys_tick)
    else $error("undivided system tick missing");

endmodule // ccrc_top

// ==== tb/ccrc_top_tb.sv ====
// Self-checking bench of the clock configuration and reset cause block
`timescale 1ns/1ns
`include "ccrc_params.svh"

module ccrc_top_tb;
  import ccrc_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  ccrc_cause_t cause_in = '0;
  ccrc_pmode_t pmode_in = CCRC_PM_RUN;
  ccrc_gating_t gating_in = '0;
  logic [31:0] periph_clk_en;
  ccrc_clkctl_t clkctl;
  logic sys_tick, pwm_tick, irq;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [31:0] rng = 32'h0000_d2e2;

  always #20 clk_sys = ~clk_sys;

  ccrc_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .cause_in(cause_in), .pmode_in(pmode_in),
    .gating_in(gating_in), .periph_clk_en(periph_clk_en), .clkctl(clkctl), .sys_tick(sys_tick),
    .pwm_tick(pwm_tick), .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // ==========================================================
  // Helpers
  function logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function ccrc_clkctl_t ectl(input logic [31:0] v);
    ectl.osc_select = v[11];
    ectl.system_divisor_active = v[22] | ~v[11];
    if (!v[11] && v[26:23] < 4'h3) ectl.system_divisor = 4'h3;
    else if (v[26:23] == 4'h0) ectl.system_divisor = 4'h1;
    else ectl.system_divisor = v[26:23];
    ectl.pwm_divided = v[20];
    ectl.pwm_divisor = (v[19:17] > 3'h5) ? 3'h5 : v[19:17];
  endfunction

  function logic [31:0] egate(input logic auto_gating_select, input logic [1:0] pm, input ccrc_gating_t g);
    if (auto_gating_select && pm == 2'h1) return g.sleep_gating_set;
    if (auto_gating_select && pm == 2'h2) return g.deep_sleep_gating_set;
    return g.run_gating_set;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus tasks
  task wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 0;
    r = 2'bxx;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!done) chk(32'h0, 32'h1, "write hung");
  endtask

  task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 0;
    d = 'x;
    r = 2'bxx;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!done) chk(32'h0, 32'h1, "read hung");
  endtask

  task wv(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, er}, "write resp");
  endtask

  task rchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e, "read data");
    chk({30'h0, r}, {30'h0, er}, "read resp");
  endtask

  task rst(input logic [5:0] c);
    @(posedge clk_sys);
    nrst <= 1'b0;
    cause_in <= c;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (14) @(posedge clk_sys);
  endtask

  // Cycles between the last two of three ticks
  task gap(input logic p, output int g);
    int t, k, s;
    t = 0;
    s = 0;
    g = 0;
    for (k = 0; k < 300 && s < 3; k++) begin
      @(posedge clk_sys);
      if ((p ? pwm_tick : sys_tick) === 1'b1) begin
        if (s > 0) g = k - t;
        t = k;
        s++;
      end
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [5:0] cz [5];
    logic [5:0] ez [5];
    logic [31:0] v;
    logic [31:0] hold;
    ccrc_clkctl_t e;
    int g, i, pm;
    cz = '{6'h01, 6'h08, 6'h06, 6'h30, 6'h01};
    ez = '{6'h01, 6'h09, 6'h0f, 6'h3f, 6'h01};
    for (i = 0; i < 5; i++) begin
      rst(cz[i]);
      rchk(`CCRC_OFF_RESET_CAUSE_RECORD, {26'h0, ez[i]}, `CCRC_RESP_OK);
    end
    rchk(`CCRC_OFF_RCC, 32'h078e_0800, `CCRC_RESP_OK);
    chk({22'h0, clkctl}, {22'h0, ectl(32'h078e_0800)}, "reset clkctl");
    $display("test cause record done");
    wv(`CCRC_OFF_RESET_CAUSE_RECORD, 32'h0000_0000, `CCRC_RESP_OK);
    rchk(`CCRC_OFF_RESET_CAUSE_RECORD, 32'h0000_0000, `CCRC_RESP_OK);
    wv(`CCRC_OFF_RESET_CAUSE_RECORD, 32'hffff_ffe4, `CCRC_RESP_OK);
    rchk(`CCRC_OFF_RESET_CAUSE_RECORD, 32'h0000_0024, `CCRC_RESP_OK);
    rchk(32'h0000_0070, 32'h0000_0000, `CCRC_RESP_ERR);
    rchk(32'h1000_005c, 32'h0000_0000, `CCRC_RESP_ERR);
    wv(32'h0000_0074, 32'hffff_ffff, `CCRC_RESP_ERR);
    $display("test software access done");
    rchk(`CCRC_OFF_IST, 32'h0000_0001, `CCRC_RESP_OK);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wv(`CCRC_OFF_IMSK, 32'h0000_0001, `CCRC_RESP_OK);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wv(`CCRC_OFF_IST, 32'h0000_0001, `CCRC_RESP_OK);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wv(`CCRC_OFF_RCC, 32'h0088_0000, `CCRC_RESP_OK);
    rchk(`CCRC_OFF_IST, 32'h0000_0002, `CCRC_RESP_OK);
    wv(`CCRC_OFF_IMSK, 32'h0000_0002, `CCRC_RESP_OK);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1, "clamp irq");
    wv(`CCRC_OFF_IST, 32'h0000_0002, `CCRC_RESP_OK);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0, "clamp irq cleared");
    $display("test interrupt done");
    for (i = 0; i < 16; i++) begin
      case (i)
        0: v = 32'h0000_0000;
        1: v = 32'h0810_0800;
        2: v = 32'h01dc_0800;
        3: v = 32'h0890_0000;
        default: v = xs() & 32'h0fde_0800;
      endcase
      // Reserved bits are written as zero
      wv(`CCRC_OFF_RCC, v, `CCRC_RESP_OK);
      repeat (2) @(posedge clk_sys);
      e = ectl(v);
      chk({22'h0, clkctl}, {22'h0, e}, "clkctl");
      rchk(`CCRC_OFF_RCC, v, `CCRC_RESP_OK);
      gap(1'b0, g);
      chk(g, e.system_divisor_active ? e.system_divisor + 1 : 1, "sys tick gap");
      gap(1'b1, g);
      chk(g, e.pwm_divided ? 2 << e.pwm_divisor : 1, "pwm tick gap");
      for (pm = 0; pm < 4; pm++) begin
        @(posedge clk_sys);
        pmode_in <= ccrc_pmode_t'(pm[1:0]);
        gating_in <= {xs(), xs(), xs()};
        repeat (2) @(posedge clk_sys);
        chk(periph_clk_en, egate(v[27], pm[1:0], gating_in), "gating");
      end
    end
    $display("test clock config done");
    // Clock enable low freezes the gating output, high resumes it
    hold = gating_in.run_gating_set;
    @(posedge clk_sys);
    ce <= 1'b0;
    gating_in <= {xs(), xs(), xs()};
    repeat (3) @(posedge clk_sys);
    chk(periph_clk_en, hold, "gating held with ce low");
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(periph_clk_en, gating_in.run_gating_set, "gating after ce high");
    $display("test clock enable done");
    print_verdict;
  end

  initial begin
    #800000;
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule // ccrc_top_tb
